// ===== flb_unit.sv
// flag generator, logic/rotate datapath and control-transfer unit
// assumes single-cycle combinational reads of data memory and stack
`default_nettype none


module flb_unit #(
  parameter logic [7:0] SP_INIT = flb_pkg::SP_RST // stack pointer after reset
) (
  input wire logic mclk, // core clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic op_valid, // an operation is offered
  input wire flb_pkg::flb_op_t op_code, // operation to perform
  output logic op_ready, // unit can take an operation
  input wire logic use_acc, // first byte operand is the accumulator
  input wire logic op_bit, // and/or/invert/zero act on a bit; one always does
  input wire flb_pkg::flb_bit_t bit_target, // where the bit operand lives
  input wire logic bit_invert, // use complement of the source bit
  input wire logic bit_in, // value of an externally addressed bit
  input wire logic [7:0] dst_byte, // first operand when not the accumulator
  input wire logic [7:0] src_byte, // second operand
  input wire logic [7:0] op_addr, // data address of the first operand
  input wire logic [15:0] next_pc, // address of the following instruction
  input wire logic [10:0] page_field, // short page target field
  input wire logic [15:0] long_target, // long call/jump target
  input wire logic [7:0] rel_offset, // signed branch offset
  input wire logic [15:0] table_pointer, // base of the indexed jump
  input wire logic psw_wr_en, // software write to the status word
  input wire logic [7:0] psw_wr_data, // value written to the status word
  input wire logic [7:0] mem_rd_data, // data memory read value
  output logic [7:0] mem_rd_addr, // data memory read address
  output logic mem_wr_en, // data memory write strobe
  output logic [7:0] mem_wr_addr, // data memory write address
  output logic [7:0] mem_wr_data, // data memory write value
  output logic bit_wr_en, // external bit write strobe
  output logic bit_wr_data, // external bit write value
  output logic [7:0] acc, // accumulator
  output logic carry_flag, // carry
  output logic aux_nibble_carry_flag, // nibble carry
  output logic twos_complement_range_flag, // signed range flag
  output logic odd_count_flag, // accumulator parity
  output logic [7:0] status_word, // flags assembled as a byte
  output logic [15:0] pc, // program counter
  output logic [7:0] sp, // stack pointer
  output logic int_reenable // pulse: re-enable current priority level
);

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH_HI, ST_POP_LO} flb_state_t;

  flb_state_t state_reg, state_next;
  logic [7:0] acc_reg, acc_next, sp_reg, sp_next;
  logic [15:0] pc_reg, pc_next, ret_reg, ret_next, tgt_reg, tgt_next;
  logic carry_reg, carry_next, aux_reg, aux_next, range_reg, range_next;
  logic odd_reg, interrupt_exit_reg, interrupt_exit_next, reen_reg, reen_next;
  logic mem_we_reg, mem_we_next, bit_we_reg, bit_we_next, bit_d_reg, bit_d_next;
  logic [7:0] mem_a_reg, mem_a_next, mem_d_reg, mem_d_next;
  logic byte_go, bit_go, taken;
  logic [7:0] byte_res;
  logic bit_res;

  // operand selection and arithmetic flag generation
  wire accept = op_valid && (state_reg == ST_IDLE);
  wire [7:0] first_op = use_acc ? acc_reg : dst_byte;
  wire is_sub = (op_code == flb_pkg::OP_SUBB);
  wire cin = (op_code == flb_pkg::OP_ADDC) || is_sub ? carry_reg : 1'b0;
  wire [8:0] full_sum = is_sub ? ({1'b0, acc_reg} - {1'b0, src_byte} - {8'h00, cin})
                               : ({1'b0, acc_reg} + {1'b0, src_byte} + {8'h00, cin});
  wire [4:0] nib_sum = is_sub ? ({1'b0, acc_reg[3:0]} - {1'b0, src_byte[3:0]} - {4'h0, cin})
                              : ({1'b0, acc_reg[3:0]} + {1'b0, src_byte[3:0]} + {4'h0, cin});
  wire [7:0] low7_sum = is_sub ? ({1'b0, acc_reg[6:0]} - {1'b0, src_byte[6:0]} - {7'h00, cin})
                               : ({1'b0, acc_reg[6:0]} + {1'b0, src_byte[6:0]} + {7'h00, cin});
  wire arith_carry = full_sum[8];
  wire arith_aux = nib_sum[4];
  wire arith_range = low7_sum[7] ^ full_sum[8];

  // bit operand and branch targets
  wire bit_cur = (bit_target == flb_pkg::BIT_CARRY) ? carry_reg :
                 (bit_target == flb_pkg::BIT_AUX) ? aux_reg :
                 (bit_target == flb_pkg::BIT_RANGE) ? range_reg : bit_in;
  wire bit_src = bit_in ^ bit_invert;
  wire [15:0] rel_target = next_pc + {{8{rel_offset[7]}}, rel_offset};
  wire [15:0] page_target = {next_pc[15:11], page_field};
  wire [15:0] index_target = table_pointer + {8'h00, acc_reg};
  wire [7:0] dec_val = first_op - 8'h01;
  wire [7:0] sp_inc = sp_reg + flb_pkg::SP_STEP;

  // the stack top is read on accept, the byte below it during the pop
  assign mem_rd_addr = (state_reg == ST_POP_LO) ? sp_reg - flb_pkg::SP_STEP : sp_reg;
  assign op_ready = (state_reg == ST_IDLE);

  // next-state datapath; one operation per accept, calls and exits take two cycles
  always_comb begin
    state_next = state_reg;
    acc_next = acc_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    ret_next = ret_reg;
    tgt_next = tgt_reg;
    carry_next = carry_reg;
    aux_next = aux_reg;
    range_next = range_reg;
    interrupt_exit_next = interrupt_exit_reg;
    reen_next = 1'b0;
    mem_we_next = 1'b0;
    mem_a_next = mem_a_reg;
    mem_d_next = mem_d_reg;
    bit_we_next = 1'b0;
    bit_d_next = bit_d_reg;
    byte_go = 1'b0;
    byte_res = first_op;
    bit_go = 1'b0;
    bit_res = bit_cur;
    taken = 1'b0;
    case (state_reg)
      ST_PUSH_HI: begin
        sp_next = sp_inc;
        mem_we_next = 1'b1;
        mem_a_next = sp_inc;
        mem_d_next = ret_reg[15:8];
        pc_next = tgt_reg;
        state_next = ST_IDLE;
      end
      ST_POP_LO: begin
        pc_next = {ret_reg[15:8], mem_rd_data};
        sp_next = sp_reg - flb_pkg::SP_POP_DROP;
        reen_next = interrupt_exit_reg;
        state_next = ST_IDLE;
      end
      default: begin
        if (accept) begin
          pc_next = next_pc;
          case (op_code)
            flb_pkg::OP_ADD, flb_pkg::OP_ADDC, flb_pkg::OP_SUBB: begin
              acc_next = full_sum[7:0];
              carry_next = arith_carry;
              aux_next = arith_aux;
              range_next = arith_range;
            end
            flb_pkg::OP_BITWISE_AND: begin
              if (op_bit) begin
                carry_next = carry_reg & bit_src;
              end else begin
                byte_go = 1'b1;
                byte_res = first_op & src_byte;
              end
            end
            flb_pkg::OP_BITWISE_OR: begin
              if (op_bit) begin
                carry_next = carry_reg | bit_src;
              end else begin
                byte_go = 1'b1;
                byte_res = first_op | src_byte;
              end
            end
            flb_pkg::OP_BITWISE_XOR: begin
              byte_go = 1'b1;
              byte_res = first_op ^ src_byte;
            end
            flb_pkg::OP_INVERT: begin
              if (op_bit) begin
                bit_go = 1'b1;
                bit_res = ~bit_cur;
              end else begin
                acc_next = ~acc_reg; // flags untouched
              end
            end
            flb_pkg::OP_BIT_ZERO: begin
              if (op_bit) begin
                bit_go = 1'b1;
                bit_res = 1'b0;
              end else begin
                acc_next = flb_pkg::ACC_RST;
              end
            end
            flb_pkg::OP_BIT_ONE: begin
              bit_go = 1'b1;
              bit_res = 1'b1;
            end
            flb_pkg::OP_ROTATE_LEFT: acc_next = {acc_reg[6:0], acc_reg[7]};
            flb_pkg::OP_ROTATE_RIGHT: acc_next = {acc_reg[0], acc_reg[7:1]};
            flb_pkg::OP_ROTATE_LEFT_THRU: begin
              acc_next = {acc_reg[6:0], carry_reg};
              carry_next = acc_reg[7];
            end
            flb_pkg::OP_ROTATE_RIGHT_THRU: begin
              acc_next = {carry_reg, acc_reg[7:1]};
              carry_next = acc_reg[0];
            end
            flb_pkg::OP_NIBBLE_SWAP: acc_next = {acc_reg[3:0], acc_reg[7:4]};
            flb_pkg::OP_SHORT_PAGE_CALL, flb_pkg::OP_LONG_CALL: begin
              sp_next = sp_inc; // low byte first
              mem_we_next = 1'b1;
              mem_a_next = sp_inc;
              mem_d_next = next_pc[7:0];
              ret_next = next_pc;
              tgt_next = (op_code == flb_pkg::OP_LONG_CALL) ? long_target : page_target;
              pc_next = pc_reg; // target loads in the second cycle, the edge before the high byte lands
              state_next = ST_PUSH_HI;
            end
            flb_pkg::OP_SHORT_PAGE_JUMP: pc_next = page_target;
            flb_pkg::OP_LONG_JUMP: pc_next = long_target;
            flb_pkg::OP_RELATIVE_JUMP: pc_next = rel_target;
            flb_pkg::OP_INDEXED_JUMP: pc_next = index_target;
            flb_pkg::OP_SUBROUTINE_EXIT, flb_pkg::OP_INTERRUPT_EXIT: begin
              ret_next = {mem_rd_data, next_pc[7:0]}; // high byte sits on top
              interrupt_exit_next = (op_code == flb_pkg::OP_INTERRUPT_EXIT);
              pc_next = pc_reg;
              state_next = ST_POP_LO;
            end
            flb_pkg::OP_BRANCH_IF_ZERO: taken = (acc_reg == 8'h00);
            flb_pkg::OP_BRANCH_IF_NONZERO: taken = (acc_reg != 8'h00);
            flb_pkg::OP_BRANCH_IF_CARRY: taken = carry_reg;
            flb_pkg::OP_BRANCH_IF_NO_CARRY: taken = ~carry_reg;
            flb_pkg::OP_BRANCH_IF_BIT_SET: taken = bit_cur;
            flb_pkg::OP_BRANCH_IF_BIT_CLEAR: taken = ~bit_cur;
            flb_pkg::OP_BRANCH_AND_CLEAR_BIT: begin
              taken = bit_cur;
              bit_go = bit_cur;
              bit_res = 1'b0;
            end
            flb_pkg::OP_COMPARE_BRANCH_UNEQUAL: begin
              taken = (first_op != src_byte);
              carry_next = (first_op < src_byte);
            end
            flb_pkg::OP_DECREMENT_BRANCH_NONZERO: begin
              byte_go = 1'b1;
              byte_res = dec_val;
              taken = (dec_val != 8'h00);
            end
            default: pc_next = next_pc;
          endcase
          if (taken) begin
            pc_next = rel_target;
          end
          // byte results return to the first operand's home
          if (byte_go && use_acc) begin
            acc_next = byte_res;
          end else if (byte_go) begin
            mem_we_next = 1'b1;
            mem_a_next = op_addr;
            mem_d_next = byte_res;
          end
          // bit results may land on a status flag
          if (bit_go) begin
            case (bit_target)
              flb_pkg::BIT_CARRY: carry_next = bit_res;
              flb_pkg::BIT_AUX: aux_next = bit_res;
              flb_pkg::BIT_RANGE: range_next = bit_res;
              default: begin
                bit_we_next = 1'b1;
                bit_d_next = bit_res;
              end
            endcase
          end
        end
      end
    endcase
    // a direct status word write wins over carry, aux and range of the same cycle
    if (psw_wr_en) begin
      carry_next = psw_wr_data[flb_pkg::SW_CARRY_BIT];
      aux_next = psw_wr_data[flb_pkg::SW_AUX_BIT];
      range_next = psw_wr_data[flb_pkg::SW_RANGE_BIT];
    end
  end

  // architectural state; everything lands on one edge so the next op sees it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      acc_reg <= flb_pkg::ACC_RST;
      sp_reg <= SP_INIT;
      pc_reg <= flb_pkg::PC_RST;
      ret_reg <= flb_pkg::PC_RST;
      tgt_reg <= flb_pkg::PC_RST;
      {carry_reg, aux_reg, range_reg, odd_reg} <= 4'h0;
      {interrupt_exit_reg, reen_reg, mem_we_reg, bit_we_reg, bit_d_reg} <= 5'h00;
      mem_a_reg <= 8'h00;
      mem_d_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      ret_reg <= ret_next;
      tgt_reg <= tgt_next;
      {carry_reg, aux_reg, range_reg} <= {carry_next, aux_next, range_next};
      odd_reg <= ^acc_next; // never from psw_wr_data
      {interrupt_exit_reg, reen_reg} <= {interrupt_exit_next, reen_next};
      {mem_we_reg, bit_we_reg, bit_d_reg} <= {mem_we_next, bit_we_next, bit_d_next};
      mem_a_reg <= mem_a_next;
      mem_d_reg <= mem_d_next;
    end
  end

  // outputs straight from registers
  assign acc = acc_reg;
  assign sp = sp_reg;
  assign pc = pc_reg;
  assign carry_flag = carry_reg;
  assign aux_nibble_carry_flag = aux_reg;
  assign twos_complement_range_flag = range_reg;
  assign odd_count_flag = odd_reg;
  assign status_word = {carry_reg, aux_reg, 3'b000, range_reg, 1'b0, odd_reg};
  assign mem_wr_en = mem_we_reg;
  assign mem_wr_addr = mem_a_reg;
  assign mem_wr_data = mem_d_reg;
  assign bit_wr_en = bit_we_reg;
  assign bit_wr_data = bit_d_reg;
  assign int_reenable = reen_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // helper: an accepted op with no concurrent status word write
  wire plain_go = accept && !psw_wr_en;

  property p_odd_tracks;
    odd_count_flag == ^acc;
  endproperty
  a_odd_tracks: assert property (p_odd_tracks) else $error("parity wrong");

  property p_psw_keeps_odd;
    psw_wr_en && !accept && state_reg == ST_IDLE |=> $stable(odd_count_flag);
  endproperty
  a_psw_keeps_odd: assert property (p_psw_keeps_odd) else $error("odd flag moved");

  property p_add_flags;
    plain_go && op_code == flb_pkg::OP_ADD |=>
      carry_flag == $past(arith_carry) && twos_complement_range_flag ==
      (($past(acc[7]) == $past(src_byte[7])) && (acc[7] != $past(acc[7])));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_invert_acc;
    plain_go && op_code == flb_pkg::OP_INVERT && !op_bit |=>
      acc == ~$past(acc) && $stable(carry_flag) && $stable(aux_nibble_carry_flag);
  endproperty
  a_invert_acc: assert property (p_invert_acc) else $error("invert wrong");

  property p_rlc;
    plain_go && op_code == flb_pkg::OP_ROTATE_LEFT_THRU |=>
      carry_flag == $past(acc[7]) && acc[0] == $past(carry_flag);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate through carry wrong");

  property p_swap;
    accept && op_code == flb_pkg::OP_NIBBLE_SWAP |=> acc == {$past(acc[3:0]), $past(acc[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_short_jump;
    accept && op_code == flb_pkg::OP_SHORT_PAGE_JUMP |=>
      pc == {$past(next_pc[15:11]), $past(page_field)};
  endproperty
  a_short_jump: assert property (p_short_jump) else $error("page target wrong");

  sequence s_push_low;
    mem_wr_en && mem_wr_addr == $past(sp) + 8'h01 && mem_wr_data == $past(next_pc[7:0]);
  endsequence
  sequence s_push_high;
    mem_wr_en && mem_wr_data == $past(next_pc[15:8], 2) && pc == $past(long_target, 2);
  endsequence
  property p_long_call;
    accept && op_code == flb_pkg::OP_LONG_CALL |=> s_push_low ##1 s_push_high;
  endproperty
  a_long_call: assert property (p_long_call) else $error("call push wrong");

  property p_exit_sp;
    accept && op_code == flb_pkg::OP_SUBROUTINE_EXIT |=>
      !op_ready ##1 (sp == $past(sp, 2) - 8'h02) && op_ready;
  endproperty
  a_exit_sp: assert property (p_exit_sp) else $error("exit stack wrong");

  property p_interrupt_exit_pulse;
    accept && op_code == flb_pkg::OP_INTERRUPT_EXIT |=> !int_reenable ##1 int_reenable;
  endproperty
  a_interrupt_exit_pulse: assert property (p_interrupt_exit_pulse) else $error("no re-enable");

  property p_compare;
    plain_go && op_code == flb_pkg::OP_COMPARE_BRANCH_UNEQUAL |=>
      carry_flag == ($past(first_op) < $past(src_byte)) &&
      pc == ($past(first_op) != $past(src_byte) ? $past(rel_target) : $past(next_pc));
  endproperty
  a_compare: assert property (p_compare) else $error("compare branch wrong");

endmodule // flb_unit

`default_nettype wire

// ===== flb_pkg.sv
// shared constants and types for the flag, logic and branch unit
// assumes an 8-bit accumulator core with a 16-bit program counter
`default_nettype none

package flb_pkg;
  // datapath widths
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int PAGE_W = 11;
  localparam int NIB_W = 4;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [15:0] PC_RST = 16'h0000;
  // stack steps
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] SP_POP_DROP = 8'h02;
  // status word bit positions
  localparam int SW_CARRY_BIT = 7;
  localparam int SW_AUX_BIT = 6;
  localparam int SW_RANGE_BIT = 2;
  localparam int SW_ODD_BIT = 0;

  // operations issued to the unit
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADDC, OP_SUBB,
    OP_BITWISE_AND, OP_BITWISE_OR, OP_BITWISE_XOR,
    OP_INVERT, OP_BIT_ZERO, OP_BIT_ONE,
    OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_LEFT_THRU, OP_ROTATE_RIGHT_THRU,
    OP_NIBBLE_SWAP,
    OP_SHORT_PAGE_CALL, OP_LONG_CALL, OP_SHORT_PAGE_JUMP, OP_LONG_JUMP,
    OP_RELATIVE_JUMP, OP_INDEXED_JUMP, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
    OP_BRANCH_IF_ZERO, OP_BRANCH_IF_NONZERO, OP_BRANCH_IF_CARRY,
    OP_BRANCH_IF_NO_CARRY, OP_BRANCH_IF_BIT_SET, OP_BRANCH_IF_BIT_CLEAR,
    OP_BRANCH_AND_CLEAR_BIT, OP_COMPARE_BRANCH_UNEQUAL, OP_DECREMENT_BRANCH_NONZERO
  } flb_op_t;

  // where a bit operand lives
  typedef enum logic [1:0] {
    BIT_EXTERNAL, BIT_CARRY, BIT_AUX, BIT_RANGE
  } flb_bit_t;
endpackage

`default_nettype wire

// ===== flb_stack_mem.sv
// data memory and stack model on the far side of the flag and branch unit
// assumes reads are combinational and writes land on the rising edge of mclk
`default_nettype none
module flb_stack_mem (
  input wire logic mclk, // core clock
  input wire logic [7:0] rd_addr, // read address
  output logic [7:0] rd_data, // read value, same cycle
  input wire logic wr_en, // write strobe
  input wire logic [7:0] wr_addr, // write address
  input wire logic [7:0] wr_data // write value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [256];
  // combinational read so the pop cycle sees its byte without a wait state
  assign rd_data = ram[rd_addr];
  // unwritten bytes stay unknown, so a pop of a byte never pushed cannot match
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      ram[wr_addr] <= wr_data;
    end
  end
endmodule // flb_stack_mem
`default_nettype wire

// ===== flb_unit_test.sv
// self-checking bench for flb_unit: a row table of accumulator ops, then hand tests
// assumes flb_pkg, flb_unit and flb_stack_mem are compiled before it
`default_nettype none
module flb_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {flb_pkg::flb_op_t op; logic [7:0] src, res; logic [2:0] f;} flb_row_t;
  logic mclk, reset_n, op_valid, op_ready, use_acc, op_bit, bit_invert, bit_in, psw_wr_en;
  logic mem_wr_en, bit_wr_en, bit_wr_data, carry_flag, aux_nibble_carry_flag;
  logic twos_complement_range_flag, odd_count_flag, int_reenable;
  flb_pkg::flb_op_t op_code;
  flb_pkg::flb_bit_t bit_target;
  logic [7:0] dst_byte, src_byte, op_addr, rel_offset, psw_wr_data, mem_rd_data, mem_rd_addr;
  logic [7:0] mem_wr_addr, mem_wr_data, acc, status_word, sp;
  logic [15:0] next_pc, long_target, table_pointer, pc;
  logic [10:0] page_field;
  int miscompares, n_tests, cyc, i;
  // rows run in order, each starting from the accumulator the previous row left
  flb_row_t rows [13] = '{
    '{flb_pkg::OP_BIT_ZERO, 8'h00, 8'h00, 3'b000}, '{flb_pkg::OP_BITWISE_OR, 8'hc3, 8'hc3, 3'b000},
    '{flb_pkg::OP_ADD, 8'haa, 8'h6d, 3'b101}, '{flb_pkg::OP_ADDC, 8'haa, 8'h18, 3'b110},
    '{flb_pkg::OP_SUBB, 8'h20, 8'hf7, 3'b100}, '{flb_pkg::OP_ROTATE_LEFT_THRU, 8'h00, 8'hef, 3'b100},
    '{flb_pkg::OP_ROTATE_RIGHT, 8'h00, 8'hf7, 3'b100}, '{flb_pkg::OP_NIBBLE_SWAP, 8'h00, 8'h7f, 3'b100},
    '{flb_pkg::OP_BITWISE_XOR, 8'hff, 8'h80, 3'b100},
    '{flb_pkg::OP_ROTATE_RIGHT_THRU, 8'h00, 8'hc0, 3'b000},
    '{flb_pkg::OP_ROTATE_LEFT, 8'h00, 8'h81, 3'b000}, '{flb_pkg::OP_INVERT, 8'h00, 8'h7e, 3'b000},
    '{flb_pkg::OP_BITWISE_AND, 8'h0f, 8'h0e, 3'b000}};

  flb_unit u_dut (.mclk, .reset_n, .op_valid, .op_code, .op_ready, .use_acc, .op_bit,
    .bit_target, .bit_invert, .bit_in, .dst_byte, .src_byte, .op_addr, .next_pc, .page_field,
    .long_target, .rel_offset, .table_pointer, .psw_wr_en, .psw_wr_data, .mem_rd_data,
    .mem_rd_addr, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .bit_wr_en, .bit_wr_data, .acc,
    .carry_flag, .aux_nibble_carry_flag, .twos_complement_range_flag, .odd_count_flag,
    .status_word, .pc, .sp, .int_reenable);
  flb_stack_mem u_mem (.mclk(mclk), .rd_addr(mem_rd_addr), .rd_data(mem_rd_data),
    .wr_en(mem_wr_en), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data));

  // 100 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_tests++;
      if (got !== exp) begin
        miscompares++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // offer one op and wait out the second cycle that calls and exits take;
  // op_valid stays up so back-to-back calls never drive it twice in one step
  task automatic do_op(input flb_pkg::flb_op_t op, input logic [7:0] src);
    int k;
    begin
      op_code = op;
      src_byte = src;
      op_valid = 1'b1;
      @(posedge mclk) #1;
      for (k = 0; k < 8 && op_ready !== 1'b1; k++) @(posedge mclk) #1;
    end
  endtask
  task automatic print_verdict;
    begin
      if (miscompares == 0 && n_tests > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  initial begin
    {reset_n, op_valid, op_bit, bit_invert, bit_in, psw_wr_en} = 6'h00;
    op_code = flb_pkg::OP_NONE;
    bit_target = flb_pkg::BIT_EXTERNAL;
    use_acc = 1'b1;
    {dst_byte, src_byte, op_addr, rel_offset, psw_wr_data} = 40'h0;
    {next_pc, long_target, table_pointer, page_field} = 59'h0;
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk(16'({acc, sp}), 16'h0007);
    chk(pc, 16'h0000);
    for (i = 0; i < 13; i++) begin
      do_op(rows[i].op, rows[i].src);
      chk(16'(acc), 16'(rows[i].res));
      chk(16'({carry_flag, aux_nibble_carry_flag, twos_complement_range_flag}), 16'(rows[i].f));
      chk(16'(odd_count_flag), 16'(^rows[i].res));
    end
    // odd flag bit written as 0 must still read as the accumulator parity
    op_valid = 1'b0;
    psw_wr_data = 8'hc4;
    psw_wr_en = 1'b1;
    @(posedge mclk) #1;
    psw_wr_en = 1'b0;
    chk(16'(status_word), 16'h00c5);
    op_bit = 1'b1;
    bit_target = flb_pkg::BIT_CARRY;
    do_op(flb_pkg::OP_BIT_ZERO, 8'h00);
    chk(16'(carry_flag), 16'h0000);
    do_op(flb_pkg::OP_BIT_ONE, 8'h00);
    chk(16'(carry_flag), 16'h0001);
    op_bit = 1'b0;
    next_pc = 16'h0100;
    rel_offset = 8'h80;
    do_op(flb_pkg::OP_BRANCH_IF_CARRY, 8'h00);
    chk(pc, 16'h0080);
    do_op(flb_pkg::OP_BRANCH_IF_ZERO, 8'h00);
    chk(pc, 16'h0100);
    rel_offset = 8'h7f;
    do_op(flb_pkg::OP_BRANCH_IF_NONZERO, 8'h00);
    chk(pc, 16'h017f);
    next_pc = 16'h0800;
    page_field = 11'h345;
    do_op(flb_pkg::OP_SHORT_PAGE_JUMP, 8'h00);
    chk(pc, 16'h0b45);
    table_pointer = 16'h0ff0;
    do_op(flb_pkg::OP_INDEXED_JUMP, 8'h00);
    chk(pc, 16'h0ffe);
    next_pc = 16'h1234;
    long_target = 16'habcd;
    do_op(flb_pkg::OP_LONG_CALL, 8'h00);
    chk(pc, 16'habcd);
    chk(16'(sp), 16'h0009);
    // the high byte lands in memory one edge after the call completes
    op_valid = 1'b0;
    @(posedge mclk) #1;
    chk({u_mem.ram[9], u_mem.ram[8]}, 16'h1234);
    do_op(flb_pkg::OP_INTERRUPT_EXIT, 8'h00);
    chk(pc, 16'h1234);
    chk(16'({sp, 7'h00, int_reenable}), 16'h0701);
    // short page call followed by a plain subroutine exit
    next_pc = 16'h0802;
    page_field = 11'h123;
    do_op(flb_pkg::OP_SHORT_PAGE_CALL, 8'h00);
    chk(pc, 16'h0923);
    op_valid = 1'b0;
    @(posedge mclk) #1;
    do_op(flb_pkg::OP_SUBROUTINE_EXIT, 8'h00);
    chk(pc, 16'h0802);
    chk(16'({sp, 7'h00, int_reenable}), 16'h0700);
    // compare 0e against 0f: unequal, first below second
    do_op(flb_pkg::OP_COMPARE_BRANCH_UNEQUAL, 8'h0f);
    chk(pc, 16'h0881);
    chk(16'(carry_flag), 16'h0001);
    print_verdict();
  end
endmodule // flb_unit_test
`default_nettype wire
